// file: epvi_regs.svh
`ifndef EPVI_REGS_SVH
`define EPVI_REGS_SVH
`define EPVI_CLK_MHZ        125
`define EPVI_PULSE_US       100
`define EPVI_PULSE_CYC      ((`EPVI_PULSE_US * `EPVI_CLK_MHZ))
`define EPVI_SETUP_US       2
`define EPVI_SETUP_CYC      ((`EPVI_SETUP_US * `EPVI_CLK_MHZ))
`define EPVI_READ_NS        200
`define EPVI_READ_CYC       ((`EPVI_READ_NS * `EPVI_CLK_MHZ + 999) / 1000)
`define EPVI_MAX_PULSES     10
`define EPVI_ADDR_W         14
`define EPVI_DATA_W         16
`define EPVI_ID_LO_BIT      0
`endif

// file: epvi_pkg.sv
package epvi_pkg;
  `include "epvi_regs.svh"
  typedef enum logic [1:0] {EPVI_OP_READ, EPVI_OP_PROG, EPVI_OP_IDENT} epvi_op_t;
  typedef enum {EPVI_IDLE, EPVI_SETUP, EPVI_PULSE, EPVI_RECOVER, EPVI_SAMPLE,
                EPVI_DONE} epvi_state_t;
  typedef struct packed {
    logic [13:0] addr;
    logic [15:0] data_out;
    logic        data_oe;
    logic        chip_sel_n;
    logic        out_gate_n;
    logic        program_strobe_low;
    logic        raised_voltage_level;
    logic        identity_select_line;
  } epvi_pins_t;
  typedef struct packed {
    logic        valid;
    epvi_op_t    op;
    logic [13:0] addr;
    logic [15:0] data;
  } epvi_req_t;
  typedef struct packed {
    logic        done;
    logic        fail;
    logic [15:0] data;
    logic [3:0]  pulses;
  } epvi_rsp_t;
  typedef struct packed {
    epvi_state_t st;
    epvi_op_t    op;
    logic [15:0] cnt;
    logic [3:0]  pulses;
    logic        ready;
    logic [15:0] wdata;
    epvi_pins_t  pins;
    epvi_rsp_t   rsp;
  } epvi_state_all_t;
endpackage

// file: epvi_prog_host.sv
// Function
// - Pulse each word up to ten times at 100 us, verifying after each.
// - Program needs raised supply, gate high, select low, strobe pulsed low.
// - Present 14-bit address and 16-bit data during programming.
// - Hold address and data stable before the low strobe pulse.
// - Verify: raised supply, gate low, select low, strobe high; device drives.
// - Read back and compare every programmed word.
// - Identity mode: identity line raised, select and gate low.
// - Identity codes may be read before programming.
// - Read mode: select and gate low, device drives stored word.
`timescale 1ns/1ps
`include "epvi_regs.svh"
module epvi_prog_host (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST_N,
  input  wire epvi_pkg::epvi_req_t  REQ,
  output logic                      REQ_READY,
  output epvi_pkg::epvi_rsp_t       RSP,
  output epvi_pkg::epvi_pins_t      PINS,
  input  wire logic [15:0]          DATA_IN
);
  import epvi_pkg::*;

  // Countdowns load one less than their span: the cycle that reads zero counts too
  function automatic logic [15:0] epvi_cyc(input int unsigned c);
    epvi_cyc = 16'(c - 1);
  endfunction

  function automatic logic epvi_expired(input logic [15:0] c);
    epvi_expired = (c == 16'h0000);
  endfunction

  function automatic logic [15:0] epvi_count_down(input logic [15:0] c);
    epvi_count_down = c - 16'h0001;
  endfunction

  function automatic logic epvi_is_prog(input epvi_op_t op);
    epvi_is_prog = (op == EPVI_OP_PROG);
  endfunction

  // A word that never verifies costs ten full rounds, about 1.1 ms, before fail
  localparam logic [15:0] setup_load = epvi_cyc(`EPVI_SETUP_CYC);
  localparam logic [15:0] pulse_load = epvi_cyc(`EPVI_PULSE_CYC);
  // The read span covers the 200 ns access time, rounded up to whole clock cycles
  localparam logic [15:0] read_load  = epvi_cyc(`EPVI_READ_CYC);
  localparam logic [3:0]  max_pulses = 4'(`EPVI_MAX_PULSES);

  // Program setup: gate closed, host drives the word, strobe still high
  function automatic epvi_pins_t epvi_pins_prog(input epvi_pins_t p);
    epvi_pins_prog                      = p;
    epvi_pins_prog.chip_sel_n           = 1'b0;
    epvi_pins_prog.out_gate_n           = 1'b1;
    epvi_pins_prog.program_strobe_low   = 1'b1;
    epvi_pins_prog.raised_voltage_level = 1'b1;
    epvi_pins_prog.identity_select_line = 1'b0;
    epvi_pins_prog.data_oe              = 1'b1;
  endfunction

  // Read, identity and verify: gate open, strobe high, host off the data bus
  function automatic epvi_pins_t epvi_pins_look(input epvi_pins_t p);
    epvi_pins_look                    = p;
    epvi_pins_look.chip_sel_n         = 1'b0;
    epvi_pins_look.out_gate_n         = 1'b0;
    epvi_pins_look.program_strobe_low = 1'b1;
    epvi_pins_look.data_oe            = 1'b0;
  endfunction

  // At rest the device is deselected and gated off, with both raised levels down
  function automatic epvi_pins_t epvi_pins_rest(input epvi_pins_t p);
    epvi_pins_rest                      = p;
    epvi_pins_rest.chip_sel_n           = 1'b1;
    epvi_pins_rest.out_gate_n           = 1'b1;
    epvi_pins_rest.program_strobe_low   = 1'b1;
    epvi_pins_rest.raised_voltage_level = 1'b0;
    epvi_pins_rest.identity_select_line = 1'b0;
    epvi_pins_rest.data_oe              = 1'b0;
  endfunction

  // Reset state is a constant so the asynchronous reset branch stays free of logic
  localparam epvi_state_all_t state_reset = '{
    st:     EPVI_IDLE,
    op:     EPVI_OP_READ,
    cnt:    16'h0000,
    pulses: 4'h0,
    ready:  1'b1,
    wdata:  16'h0000,
    pins:   epvi_pins_rest('0),
    rsp:    '{
      done:   1'b0,
      fail:   1'b0,
      data:   16'h0000,
      pulses: 4'h0
    }
  };

  epvi_state_all_t s;
  epvi_state_all_t next_s;

  // One transfer at a time; a request seen while ready is low is not taken,
  // so the caller keeps it up until ready shows
  always_comb begin
    next_s          = s;
    next_s.rsp.done = 1'b0;

    unique case (s.st)
      EPVI_IDLE: begin
        if (REQ.valid) begin
          next_s.op        = REQ.op;
          next_s.wdata     = REQ.data;
          next_s.pulses    = 4'h0;
          next_s.ready     = 1'b0;
          next_s.rsp.fail  = 1'b0;
          next_s.cnt       = setup_load;
          next_s.st        = EPVI_SETUP;
          next_s.pins.addr = REQ.addr;
          if (epvi_is_prog(REQ.op)) begin
            // Erased cells read one, so the zeros of this word are the bits that get written
            next_s.pins          = epvi_pins_prog(next_s.pins);
            next_s.pins.data_out = REQ.data;
          end else begin
            next_s.pins                      = epvi_pins_look(next_s.pins);
            next_s.pins.raised_voltage_level = 1'b0;
            // Identity is a read with the select line raised; it may come before programming
            next_s.pins.identity_select_line = (REQ.op == EPVI_OP_IDENT);
          end
        end
      end

      EPVI_SETUP: begin
        if (!epvi_expired(s.cnt)) begin
          next_s.cnt = epvi_count_down(s.cnt);
        end else if (epvi_is_prog(s.op)) begin
          // Address and data have stood for a full setup span before the strobe falls
          next_s.pins.program_strobe_low = 1'b0;
          next_s.pulses                  = s.pulses + 4'h1;
          next_s.cnt                     = pulse_load;
          next_s.st                      = EPVI_PULSE;
        end else begin
          // Read and identity wait one access span before the word is sampled
          next_s.cnt = read_load;
          next_s.st  = EPVI_SAMPLE;
        end
      end

      EPVI_PULSE: begin
        if (!epvi_expired(s.cnt)) begin
          next_s.cnt = epvi_count_down(s.cnt);
        end else begin
          // Data stays driven past the strobe rise to give the cell its hold time
          next_s.pins.program_strobe_low = 1'b1;
          next_s.cnt                     = setup_load;
          next_s.st                      = EPVI_RECOVER;
        end
      end

      EPVI_RECOVER: begin
        if (!epvi_expired(s.cnt)) begin
          next_s.cnt = epvi_count_down(s.cnt);
        end else begin
          // The supply stays raised, so the device answers in verify mode
          next_s.pins = epvi_pins_look(s.pins);
          next_s.cnt  = setup_load;
          next_s.st   = EPVI_SAMPLE;
        end
      end

      EPVI_SAMPLE: begin
        if (!epvi_expired(s.cnt)) begin
          next_s.cnt = epvi_count_down(s.cnt);
        end else begin
          next_s.rsp.data = DATA_IN;
          if (!epvi_is_prog(s.op)) begin
            next_s.st = EPVI_DONE;
          end else if (DATA_IN == s.wdata) begin
            // No extra pulse once the word reads back right
            next_s.st = EPVI_DONE;
          end else if (s.pulses == max_pulses) begin
            next_s.rsp.fail = 1'b1;
            next_s.st       = EPVI_DONE;
          end else begin
            // Gate closes and the word is driven again before the next setup span
            next_s.pins = epvi_pins_prog(s.pins);
            next_s.cnt  = setup_load;
            next_s.st   = EPVI_SETUP;
          end
        end
      end

      EPVI_DONE: begin
        // Done pulses for one cycle while the pins return to rest
        next_s.rsp.done   = 1'b1;
        next_s.rsp.pulses = s.pulses;
        next_s.ready      = 1'b1;
        next_s.pins       = epvi_pins_rest(s.pins);
        next_s.st         = EPVI_IDLE;
      end
    endcase
  end

  // Reset drops every pin to rest at once, so the raised levels never outlive it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s <= state_reset;
    end else begin
      s <= next_s;
    end
  end

  // Outputs are copies of state flops; no gate sits between a flop and a pin
  assign REQ_READY = s.ready;
  assign RSP       = s.rsp;
  assign PINS      = s.pins;
endmodule

// file: epvi_prog_host_monitor.sv
`timescale 1ns/1ps
module epvi_prog_host_monitor (
  input wire logic                 CLK_SYS,
  input wire logic                 RST_N,
  input wire epvi_pkg::epvi_req_t  REQ,
  input wire logic                 REQ_READY,
  input wire epvi_pkg::epvi_rsp_t  RSP,
  input wire epvi_pkg::epvi_pins_t PINS,
  input wire logic [15:0]          DATA_IN
);
  import epvi_pkg::*;
  logic [13:0] low_cnt;
  wire s = PINS.program_strobe_low, g = PINS.out_gate_n, c = PINS.chip_sel_n;
  wire v = PINS.raised_voltage_level, e = PINS.data_oe;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) low_cnt <= 14'h0000;
    else low_cnt <= s ? 14'h0000 : low_cnt + 14'h0001;
  end
  a_prog_entry: assert property (!s |-> v && g && !c && e)
    else $error("strobe low outside program setup");
  a_pulse_width: assert property ($rose(s) |-> low_cnt == 14'h30d4)
    else $error("program pulse width wrong");
  a_hold_stable: assert property (!s ##1 !s |-> $stable(PINS.addr) && $stable(PINS.data_out))
    else $error("address or data moved in pulse");
  a_verify_pins: assert property (v && !g |-> s && !c && !e)
    else $error("bad verify pins");
  a_ident_pins: assert property (PINS.identity_select_line |-> !c && !g && !v && s)
    else $error("bad identity pins");
  a_take_present: assert property (REQ.valid && REQ_READY && REQ.op == EPVI_OP_PROG |->
    ##1 e && PINS.addr == $past(REQ.addr) && PINS.data_out == $past(REQ.data))
    else $error("word not presented");
  a_pulse_cap: assert property (RSP.pulses <= 4'ha)
    else $error("too many pulses");
  a_ready_quiet: assert property (REQ_READY |-> s && !e)
    else $error("idle host drives pins");
  c_prog: cover property ($rose(s));
  c_ident: cover property (PINS.identity_select_line);
  c_two_pulses: cover property (RSP.done && RSP.pulses == 4'h2);
endmodule
bind epvi_prog_host epvi_prog_host_monitor epvi_prog_host_monitor_i (.CLK_SYS(CLK_SYS),
  .RST_N(RST_N), .REQ(REQ), .REQ_READY(REQ_READY), .RSP(RSP), .PINS(PINS), .DATA_IN(DATA_IN));

// file: epvi_dev_model.sv
`timescale 1ns/1ps
module epvi_dev_model #(
  parameter logic [7:0] MAKER = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART  = 8'hc3  // Arbitrary value
) (
  input  wire logic                 CLK_SYS,
  input  wire epvi_pkg::epvi_pins_t PINS,
  input  wire logic                 WEAK,
  output logic [15:0]               DATA_IN
);
  import epvi_pkg::*;
  logic [15:0] mem [16384];
  logic [15:0] last = 16'h0000;
  logic        skip = 1'b1;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  always @(posedge CLK_SYS) last <= DATA_IN;
  always @(negedge PINS.program_strobe_low) begin
    if (PINS.raised_voltage_level && PINS.out_gate_n && !PINS.chip_sel_n) begin
      if (WEAK && skip) skip = 1'b0; // Slow cell loses its first pulse
      else mem[PINS.addr] = mem[PINS.addr] & PINS.data_out;
    end
  end
  always_comb begin
    if (PINS.data_oe) DATA_IN = PINS.data_out;
    else if (!PINS.chip_sel_n && !PINS.out_gate_n && PINS.program_strobe_low)
      DATA_IN = PINS.identity_select_line ? {8'h00, PINS.addr[0] ? PART : MAKER}
        : mem[PINS.addr];
    else DATA_IN = ~last;
  end
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
  import epvi_pkg::*;
  typedef struct packed {epvi_op_t op; logic [13:0] a; logic [15:0] d, x;} epvi_row_t;
  logic        CLK_SYS = 1'b0, RST_N = 1'b0, READY, WEAK = 1'b0;
  epvi_req_t   REQ = '0;
  epvi_rsp_t   RSP;
  epvi_pins_t  PINS;
  logic [15:0] DATA_IN;
  int          bad_count = 0, cmp_count = 0;
  epvi_row_t   rows [8] = '{'{EPVI_OP_IDENT, 14'h0000, 16'h0000, 16'h005a},
    '{EPVI_OP_IDENT, 14'h0001, 16'h0000, 16'h00c3}, '{EPVI_OP_READ, 14'h0005, 16'h0000, 16'hffff},
    '{EPVI_OP_PROG, 14'h0005, 16'ha5c3, 16'ha5c3}, '{EPVI_OP_READ, 14'h0005, 16'h0000, 16'ha5c3},
    '{EPVI_OP_PROG, 14'h3fff, 16'h0000, 16'h0000}, '{EPVI_OP_READ, 14'h3fff, 16'h0000, 16'h0000},
    '{EPVI_OP_READ, 14'h0004, 16'h0000, 16'hffff}};
  always #4 CLK_SYS = ~CLK_SYS;
  epvi_prog_host epvi_prog_host_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .REQ(REQ),
    .REQ_READY(READY), .RSP(RSP), .PINS(PINS), .DATA_IN(DATA_IN));
  epvi_dev_model epvi_dev_model_i (.CLK_SYS(CLK_SYS), .PINS(PINS), .WEAK(WEAK), .DATA_IN(DATA_IN));
  task chk(string n, logic [15:0] x, logic [15:0] g);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR %s exp %h got %h", n, x, g);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task go(epvi_op_t op, logic [13:0] a, logic [15:0] d);
    @(posedge CLK_SYS) REQ <= '{1'b1, op, a, d};
    @(posedge CLK_SYS) REQ.valid <= 1'b0;
  endtask
  task fin;
    for (int n = 0; n < 28000 && RSP.done !== 1'b1; n++) @(negedge CLK_SYS);
    chk("done", 16'h0001, {15'h0000, RSP.done});
    chk("ready", 16'h0001, {15'h0000, READY});
  endtask
  initial begin
    repeat (20) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    foreach (rows[i]) begin
      go(rows[i].op, rows[i].a, rows[i].d);
      fin;
      chk("word", rows[i].x, RSP.data);
      chk("fail", 16'h0000, {15'h0000, RSP.fail});
    end
    WEAK <= 1'b1;
    go(EPVI_OP_PROG, 14'h0009, 16'h1234);
    repeat (10) @(posedge CLK_SYS);
    chk("busy", 16'h0000, {15'h0000, READY});
    REQ <= '{1'b1, EPVI_OP_PROG, 14'h0007, 16'h0000};
    repeat (3) @(posedge CLK_SYS);
    REQ.valid <= 1'b0;
    fin;
    chk("pulses", 16'h0002, {12'h000, RSP.pulses});
    chk("weak word", 16'h1234, RSP.data);
    go(EPVI_OP_READ, 14'h0007, 16'h0000);
    fin;
    chk("busy take", 16'hffff, RSP.data);
    go(EPVI_OP_PROG, 14'h0002, 16'h0000);
    repeat (100) @(posedge CLK_SYS);
    RST_N <= 1'b0;
    @(negedge CLK_SYS);
    chk("reset pins", 16'h0003, {14'h0000, PINS.chip_sel_n, PINS.out_gate_n});
    chk("reset ready", 16'h0004, {13'h0000, READY, PINS.raised_voltage_level, PINS.data_oe});
    @(posedge CLK_SYS) RST_N <= 1'b1;
    go(EPVI_OP_READ, 14'h0002, 16'h0000);
    fin;
    chk("aborted", 16'hffff, RSP.data);
    stop_test;
  end
  initial begin
    #600000;
    bad_count++;
    stop_test;
  end
endmodule
